// *** design/fifo_flags_pkg.sv ***
// package of constants for the fifo with status flags and handshake
// assumes one common clock and an active-low asynchronous reset
// Functional notes
// - near-full when exactly one free slot
// - near-empty when exactly one word held
// - write acknowledge marks an accepted write
// - overflow marks a rejected write
// - read valid marks valid output data
// - underflow marks a refused read
// - handshake outputs have selectable polarity, high default
// - single-constant full uses assert threshold only
// - multiple-constant full adds a negate threshold
// - single-constant empty uses assert threshold only
// - multiple-constant empty adds a negate threshold
// - full flags reset value is configurable
package fifo_flags_pkg;
    localparam int DATA_WIDTH_DEF = 18;
    localparam int DEPTH_DEF = 32;
    localparam int FULL_ASSERT_DEF = 30;
    localparam int FULL_NEGATE_DEF = 29;
    localparam int EMPTY_ASSERT_DEF = 2;
    localparam int EMPTY_NEGATE_DEF = 3;
    localparam logic FULL_RESET_VALUE_DEF = 1'b0;
    localparam logic POLARITY_HIGH = 1'b1;
    localparam logic POLARITY_LOW = 1'b0;

    // programmable threshold modes
    typedef enum logic [2:0] {
        PROG_OFF = 3'b001,
        PROG_SINGLE = 3'b010,
        PROG_MULTI = 3'b100
    } prog_mode_t;
endpackage

// *** design/fifo_store.sv ***
// flip-flop storage fifo with valid and ready on both sides
// assumes a common clock; the read side may stall to fill it
`timescale 1ns/1ps
module fifo_store
    import fifo_flags_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH_DEF,
    parameter int DEPTH = DEPTH_DEF,
    parameter int AW = $clog2(DEPTH)
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [AW:0] count_o
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
    logic [AW:0] count, next_count;
    logic do_write, do_read;

    // wrap a pointer at the depth, which need not be a power of two
    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    // pointer and occupancy update
    always_comb begin
        do_write = in_valid_i && (count != (AW+1)'(DEPTH));
        do_read = out_ready_i && (count != '0);
        next_wptr = do_write ? bump(wptr) : wptr;
        next_rptr = do_read ? bump(rptr) : rptr;
        next_count = count;
        if (do_write && !do_read) begin
            next_count = count + 1'b1;
        end else if (do_read && !do_write) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end

    // storage has no reset; it is never read before written
    always_ff @(posedge clock_i) begin
        if (do_write) begin
            mem[wptr] <= in_data_i;
        end
    end

    assign in_ready_o = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rptr];
    assign count_o = count;
endmodule

// *** design/thresh_flag.sv ***
// hysteresis flag for programmable full or empty levels
// assumes occupancy comes from the fifo in the same clock domain
`timescale 1ns/1ps
module thresh_flag
    import fifo_flags_pkg::*;
#(
    parameter int AW = 5,
    parameter prog_mode_t MODE = PROG_SINGLE,
    parameter logic HIGH_SIDE = 1'b1,
    parameter int ASSERT_LVL = FULL_ASSERT_DEF,
    parameter int NEGATE_LVL = FULL_NEGATE_DEF
) (
    input wire logic [AW:0] level_i,
    input wire logic flag_i,
    output logic next_flag_o
);
    // multi-mode high side sets at or above assert, clears below negate; single mode clears below assert
    always_comb begin
        next_flag_o = 1'b0;
        case (MODE)
            PROG_SINGLE: begin
                if (HIGH_SIDE) begin
                    next_flag_o = level_i >= (AW+1)'(ASSERT_LVL);
                end else begin
                    next_flag_o = level_i <= (AW+1)'(ASSERT_LVL);
                end
            end
            PROG_MULTI: begin
                if (HIGH_SIDE) begin
                    if (level_i >= (AW+1)'(ASSERT_LVL)) begin
                        next_flag_o = 1'b1;
                    end else if (level_i < (AW+1)'(NEGATE_LVL)) begin
                        next_flag_o = 1'b0;
                    end else begin
                        next_flag_o = flag_i;
                    end
                end else begin
                    if (level_i <= (AW+1)'(ASSERT_LVL)) begin
                        next_flag_o = 1'b1;
                    end else if (level_i > (AW+1)'(NEGATE_LVL)) begin
                        next_flag_o = 1'b0;
                    end else begin
                        next_flag_o = flag_i;
                    end
                end
            end
            default: next_flag_o = 1'b0;
        endcase
    end
endmodule

// *** design/fifo_flags.sv ***
// top: fifo with near flags, programmable flags and handshake flags
// assumes user write and read logic on the same clock as this block
`timescale 1ns/1ps
module fifo_flags
    import fifo_flags_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH_DEF,
    parameter int DEPTH = DEPTH_DEF,
    parameter bit NEAR_FULL_EN = 1'b1,
    parameter bit NEAR_EMPTY_EN = 1'b1,
    parameter bit ACK_EN = 1'b1,
    parameter bit OVERFLOW_EN = 1'b1,
    parameter bit VALID_EN = 1'b1,
    parameter bit UNDERFLOW_EN = 1'b1,
    parameter logic ACK_POL = POLARITY_HIGH,
    parameter logic OVERFLOW_POL = POLARITY_HIGH,
    parameter logic VALID_POL = POLARITY_HIGH,
    parameter logic UNDERFLOW_POL = POLARITY_HIGH,
    parameter prog_mode_t FULL_MODE = PROG_SINGLE,
    parameter int FULL_ASSERT = FULL_ASSERT_DEF,
    parameter int FULL_NEGATE = FULL_NEGATE_DEF,
    parameter prog_mode_t EMPTY_MODE = PROG_SINGLE,
    parameter int EMPTY_ASSERT = EMPTY_ASSERT_DEF,
    parameter int EMPTY_NEGATE = EMPTY_NEGATE_DEF,
    parameter logic FULL_RESET_VALUE = FULL_RESET_VALUE_DEF
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic wr_en_i,
    input wire logic [WIDTH-1:0] wr_data_i,
    input wire logic rd_en_i,
    output logic [WIDTH-1:0] rd_data_o,
    output logic full_o,
    output logic empty_o,
    output logic near_full_o,
    output logic near_empty_o,
    output logic prog_full_o,
    output logic prog_empty_o,
    output logic wr_ack_o,
    output logic overflow_o,
    output logic rd_valid_o,
    output logic underflow_o
);
    localparam int AW = $clog2(DEPTH);

    logic [AW:0] count;
    logic in_ready, head_valid;
    logic [WIDTH-1:0] head_data;
    logic take_wr, take_rd;
    logic [AW:0] next_level;
    logic next_full, next_empty, next_near_full, next_near_empty;
    logic next_pf, next_pe, next_ack, next_ovf, next_val, next_unf;
    logic [WIDTH-1:0] next_rd_data;
    logic next_prog_full, next_prog_empty;
    logic next_wr_ack, next_overflow, next_rd_valid, next_underflow;
    logic full, empty, near_full, near_empty, pf, pe;
    logic ack_raw, ovf_raw, val_raw, unf_raw;
    logic [WIDTH-1:0] rd_data;
    logic in_reset;

    // drive an active level of the selected polarity
    function automatic logic polar(input logic active, input logic pol);
        return pol ? active : ~active;
    endfunction

    // flags use the level after this cycle's accesses
    always_comb begin
        take_wr = wr_en_i && in_ready;
        take_rd = rd_en_i && head_valid;
        next_level = count;
        if (take_wr && !take_rd) begin
            next_level = count + 1'b1;
        end else if (take_rd && !take_wr) begin
            next_level = count - 1'b1;
        end
    end

    fifo_store #(
        .WIDTH(WIDTH),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_store (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .in_data_i(wr_data_i),
        .in_valid_i(wr_en_i),
        .in_ready_o(in_ready),
        .out_data_o(head_data),
        .out_valid_o(head_valid),
        .out_ready_i(rd_en_i),
        .count_o(count)
    );

    thresh_flag #(
        .AW(AW),
        .MODE(FULL_MODE),
        .HIGH_SIDE(1'b1),
        .ASSERT_LVL(FULL_ASSERT),
        .NEGATE_LVL(FULL_NEGATE)
    ) u_pf (
        .level_i(next_level),
        .flag_i(pf),
        .next_flag_o(next_pf)
    );

    thresh_flag #(
        .AW(AW),
        .MODE(EMPTY_MODE),
        .HIGH_SIDE(1'b0),
        .ASSERT_LVL(EMPTY_ASSERT),
        .NEGATE_LVL(EMPTY_NEGATE)
    ) u_pe (
        .level_i(next_level),
        .flag_i(pe),
        .next_flag_o(next_pe)
    );

    // occupancy flags and handshake events; full-type flags are loaded low on the
    // first edge after reset so the reset choice never reads as occupancy
    always_comb begin
        next_full = !in_reset && (next_level == (AW+1)'(DEPTH));
        next_empty = next_level == '0;
        next_near_full = !in_reset && NEAR_FULL_EN
            && (next_level == (AW+1)'(DEPTH - 1));
        next_near_empty = NEAR_EMPTY_EN && (next_level == (AW+1)'(1));
        next_prog_full = !in_reset && (FULL_MODE != PROG_OFF) && next_pf;
        next_prog_empty = (EMPTY_MODE != PROG_OFF) && next_pe;
        next_ack = ACK_EN && take_wr;
        next_ovf = OVERFLOW_EN && wr_en_i && !in_ready;
        next_val = VALID_EN && take_rd;
        next_unf = UNDERFLOW_EN && rd_en_i && !head_valid;
        // polarity applied here so the output flops only register
        next_wr_ack = polar(next_ack, ACK_POL);
        next_overflow = polar(next_ovf, OVERFLOW_POL);
        next_rd_valid = polar(next_val, VALID_POL);
        next_underflow = polar(next_unf, UNDERFLOW_POL);
        next_rd_data = take_rd ? head_data : rd_data;
    end

    // full-type flags hold the chosen value through reset, then one cycle
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            full <= FULL_RESET_VALUE;
            near_full <= FULL_RESET_VALUE;
            pf <= FULL_RESET_VALUE;
            empty <= 1'b1;
            near_empty <= 1'b0;
            pe <= 1'b0;
            ack_raw <= 1'b0;
            ovf_raw <= 1'b0;
            val_raw <= 1'b0;
            unf_raw <= 1'b0;
            rd_data <= '0;
            in_reset <= 1'b1;
        end else begin
            full <= next_full;
            near_full <= next_near_full;
            pf <= next_prog_full;
            empty <= next_empty;
            near_empty <= next_near_empty;
            pe <= next_prog_empty;
            ack_raw <= next_ack;
            ovf_raw <= next_ovf;
            val_raw <= next_val;
            unf_raw <= next_unf;
            rd_data <= next_rd_data;
            in_reset <= 1'b0;
        end
    end

    // polarity registers so every output comes straight from a flop
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ack_o <= ~ACK_POL;
            overflow_o <= ~OVERFLOW_POL;
            rd_valid_o <= ~VALID_POL;
            underflow_o <= ~UNDERFLOW_POL;
        end else begin
            wr_ack_o <= next_wr_ack;
            overflow_o <= next_overflow;
            rd_valid_o <= next_rd_valid;
            underflow_o <= next_underflow;
        end
    end

    assign full_o = full;
    assign empty_o = empty;
    assign near_full_o = near_full;
    assign near_empty_o = near_empty;
    assign prog_full_o = pf;
    assign prog_empty_o = pe;
    assign rd_data_o = rd_data;

    // acknowledge follows an accepted write by one cycle
    a_ack_follows_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ACK_EN && wr_en_i && !full |=> wr_ack_o == ACK_POL)
        else $error("write accepted without acknowledge");
    // overflow follows a write into a full fifo
    a_overflow_on_full: assert property (@(posedge clock_i) disable iff (!rstn_i)
        OVERFLOW_EN && wr_en_i && full && !in_reset |=> overflow_o == OVERFLOW_POL)
        else $error("write into full fifo not flagged");
    // ack and overflow never both active
    a_ack_ovf_excl: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !((wr_ack_o == ACK_POL) && (overflow_o == OVERFLOW_POL)))
        else $error("ack and overflow together");
    // underflow follows a read of an empty fifo
    a_underflow_empty: assert property (@(posedge clock_i) disable iff (!rstn_i)
        UNDERFLOW_EN && rd_en_i && empty |=> underflow_o == UNDERFLOW_POL)
        else $error("read of empty fifo not flagged");
    // valid read data follows a read of a non-empty fifo
    a_valid_after_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
        VALID_EN && rd_en_i && !empty |=> rd_valid_o == VALID_POL)
        else $error("read without valid");
    // near-full tracks a single free slot
    a_near_full_level: assert property (@(posedge clock_i) disable iff (!rstn_i)
        NEAR_FULL_EN && !$past(in_reset) && !in_reset
        |-> near_full == (count == (AW+1)'(DEPTH - 1)))
        else $error("near-full wrong");
    // near-empty tracks a single held word
    a_near_empty_level: assert property (@(posedge clock_i) disable iff (!rstn_i)
        NEAR_EMPTY_EN && !in_reset |-> near_empty == (count == (AW+1)'(1)))
        else $error("near-empty wrong");
    // programmable full set at assert level
    a_prog_full_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
        FULL_MODE != PROG_OFF && !in_reset && count >= (AW+1)'(FULL_ASSERT)
        |-> pf)
        else $error("prog full missing");
    // multi mode keeps the flag until below negate level
    a_prog_full_hyst: assert property (@(posedge clock_i) disable iff (!rstn_i)
        FULL_MODE == PROG_MULTI && !in_reset && $fell(pf)
        |-> count < (AW+1)'(FULL_NEGATE))
        else $error("prog full cleared early");
    // programmable empty set at assert level
    a_prog_empty_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
        EMPTY_MODE != PROG_OFF && !in_reset && count <= (AW+1)'(EMPTY_ASSERT)
        |-> pe)
        else $error("prog empty missing");
    // multi mode empty flag clears only above negate level
    a_prog_empty_hyst: assert property (@(posedge clock_i) disable iff (!rstn_i)
        EMPTY_MODE == PROG_MULTI && $fell(pe) |-> count > (AW+1)'(EMPTY_NEGATE))
        else $error("prog empty cleared early");
    // full-type flags show the reset choice on the first cycle
    a_full_reset_val: assert property (@(posedge clock_i) disable iff (!rstn_i)
        in_reset |-> full == FULL_RESET_VALUE && pf == FULL_RESET_VALUE)
        else $error("full reset value wrong");
    // raw events and polarity-mapped outputs always agree
    a_hs_polarity: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ((wr_ack_o == ACK_POL) == ack_raw)
        && ((overflow_o == OVERFLOW_POL) == ovf_raw)
        && ((rd_valid_o == VALID_POL) == val_raw)
        && ((underflow_o == UNDERFLOW_POL) == unf_raw))
        else $error("handshake polarity wrong");
    // an acknowledge only ever follows a stored write
    a_ack_has_cause: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ack_raw |-> $past(take_wr))
        else $error("acknowledge without write");
    // overflow only follows a refused write
    a_ovf_has_cause: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ovf_raw |-> $past(wr_en_i) && !$past(in_ready))
        else $error("overflow without refused write");
    // a refused write with no read leaves the fifo full
    a_overflow_no_store: assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr_en_i && !in_ready && !rd_en_i |=> count == (AW+1)'(DEPTH))
        else $error("refused write changed level");
    // valid only follows an honoured read
    a_val_has_cause: assert property (@(posedge clock_i) disable iff (!rstn_i)
        val_raw |-> $past(take_rd))
        else $error("valid without read");
    // the word shown as valid is the one that was at the head
    a_valid_data_head: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rd_en_i && head_valid |=> rd_data == $past(head_data))
        else $error("read data not head word");
    // underflow only follows a refused read
    a_unf_has_cause: assert property (@(posedge clock_i) disable iff (!rstn_i)
        unf_raw |-> $past(rd_en_i) && !$past(head_valid))
        else $error("underflow without refused read");
    // a refused read leaves the output word alone
    a_underflow_keeps: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rd_en_i && !head_valid |=> $stable(rd_data))
        else $error("refused read changed data");
    // near-full stays quiet when the option is off
    a_near_full_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !NEAR_FULL_EN && !in_reset |-> !near_full)
        else $error("disabled near-full active");
    // near-empty stays quiet when the option is off
    a_near_empty_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !NEAR_EMPTY_EN |-> !near_empty)
        else $error("disabled near-empty active");
    // disabled handshake options never raise an event
    a_handshake_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (ACK_EN || !ack_raw) && (OVERFLOW_EN || !ovf_raw)
        && (VALID_EN || !val_raw) && (UNDERFLOW_EN || !unf_raw))
        else $error("disabled handshake active");
    // programmable full stays low when switched off
    a_prog_full_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
        FULL_MODE == PROG_OFF && !in_reset |-> !pf)
        else $error("prog full active while off");
    // programmable empty stays low when switched off
    a_prog_empty_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
        EMPTY_MODE == PROG_OFF |-> !pe)
        else $error("prog empty active while off");
    // single constant: plain compare, any negate level ignored
    a_prog_full_single: assert property (@(posedge clock_i) disable iff (!rstn_i)
        FULL_MODE == PROG_SINGLE && !in_reset |-> pf == (count >= (AW+1)'(FULL_ASSERT)))
        else $error("single prog full wrong");
    // single constant: plain compare on the empty side
    a_prog_empty_single: assert property (@(posedge clock_i) disable iff (!rstn_i)
        EMPTY_MODE == PROG_SINGLE && !in_reset |-> pe == (count <= (AW+1)'(EMPTY_ASSERT)))
        else $error("single prog empty wrong");
    // dual constants: the full flag only rises at the assert level
    a_prog_full_rise: assert property (@(posedge clock_i) disable iff (!rstn_i)
        FULL_MODE == PROG_MULTI && !in_reset && $rose(pf) |-> count >= (AW+1)'(FULL_ASSERT))
        else $error("prog full rose early");
    // dual constants: the empty flag only rises at the assert level
    a_prog_empty_rise: assert property (@(posedge clock_i) disable iff (!rstn_i)
        EMPTY_MODE == PROG_MULTI && $rose(pe) |-> count <= (AW+1)'(EMPTY_ASSERT))
        else $error("prog empty rose early");
    // full follows occupancy once out of reset
    a_full_level: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !in_reset |-> full == (count == (AW+1)'(DEPTH)))
        else $error("full flag wrong");
endmodule

// *** verif/user_side.sv ***
// model of the user write and read logic that drives the fifo requests
// assumes the bench calls drive just after a rising clock edge
`timescale 1ns/1ps
module user_side
    import fifo_flags_pkg::*;
#(
    parameter int WIDTH = DATA_WIDTH_DEF
) (
    output logic wr_en_o,
    output logic [WIDTH-1:0] wr_data_o,
    output logic rd_en_o
);
    // idle data flips each call so a stale word never passes for a match
    task automatic drive(input logic w, input logic r, input logic [WIDTH-1:0] d);
        wr_en_o = w;
        rd_en_o = r;
        wr_data_o = w ? d : ~wr_data_o;
    endtask

    // quiet request lines from time zero
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wr_data_o = '0;
    end
endmodule

// *** verif/fifo_flags_tb.sv ***
// bench for the fifo with near, programmable and handshake flags
// assumes one default instance, one with dual thresholds and low polarity, and one with every option off
`timescale 1ns/1ps
module fifo_flags_tb
    import fifo_flags_pkg::*;
;
    localparam int W = DATA_WIDTH_DEF;
    localparam int D = DEPTH_DEF;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic wr_en;
    logic rd_en;
    logic [W-1:0] wr_data;
    logic [W-1:0] rd_u;
    logic [W-1:0] rd_m;
    logic [W-1:0] exp_rd;
    logic [9:0] fl_u;
    logic [9:0] fl_m;
    logic [W-1:0] rd_o;
    logic [9:0] fl_o;
    logic pf_m;
    logic pe_m;
    logic [W-1:0] q[$];
    int level = 0;
    int n_mismatch = 0;
    int n_compared = 0;

    // 50 MHz clock
    always #10 clock = ~clock;

    user_side #(.WIDTH(W)) user_u (.wr_en_o(wr_en), .wr_data_o(wr_data), .rd_en_o(rd_en));

    // flag bits: full, empty, near full, near empty, prog full, prog empty, handshakes
    fifo_flags dut_u (
        .clock_i(clock), .rstn_i(rstn), .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .rd_data_o(rd_u), .full_o(fl_u[0]), .empty_o(fl_u[1]),
        .near_full_o(fl_u[2]), .near_empty_o(fl_u[3]), .prog_full_o(fl_u[4]),
        .prog_empty_o(fl_u[5]), .wr_ack_o(fl_u[6]), .overflow_o(fl_u[7]),
        .rd_valid_o(fl_u[8]), .underflow_o(fl_u[9])
    );

    // second view: hysteresis thresholds, inverted handshakes, full flags high in reset
    fifo_flags #(
        .ACK_POL(POLARITY_LOW), .OVERFLOW_POL(POLARITY_LOW), .VALID_POL(POLARITY_LOW),
        .UNDERFLOW_POL(POLARITY_LOW), .FULL_MODE(PROG_MULTI), .EMPTY_MODE(PROG_MULTI),
        .FULL_RESET_VALUE(1'b1)
    ) dut_m (
        .clock_i(clock), .rstn_i(rstn), .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .rd_data_o(rd_m), .full_o(fl_m[0]), .empty_o(fl_m[1]),
        .near_full_o(fl_m[2]), .near_empty_o(fl_m[3]), .prog_full_o(fl_m[4]),
        .prog_empty_o(fl_m[5]), .wr_ack_o(fl_m[6]), .overflow_o(fl_m[7]),
        .rd_valid_o(fl_m[8]), .underflow_o(fl_m[9])
    );

    // third view: every optional flag, handshake and programmable level off
    fifo_flags #(
        .NEAR_FULL_EN(1'b0), .NEAR_EMPTY_EN(1'b0), .ACK_EN(1'b0), .OVERFLOW_EN(1'b0),
        .VALID_EN(1'b0), .UNDERFLOW_EN(1'b0), .FULL_MODE(PROG_OFF), .EMPTY_MODE(PROG_OFF)
    ) dut_o (
        .clock_i(clock), .rstn_i(rstn), .wr_en_i(wr_en), .wr_data_i(wr_data),
        .rd_en_i(rd_en), .rd_data_o(rd_o), .full_o(fl_o[0]), .empty_o(fl_o[1]),
        .near_full_o(fl_o[2]), .near_empty_o(fl_o[3]), .prog_full_o(fl_o[4]),
        .prog_empty_o(fl_o[5]), .wr_ack_o(fl_o[6]), .overflow_o(fl_o[7]),
        .rd_valid_o(fl_o[8]), .underflow_o(fl_o[9])
    );

    task automatic end_sim();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the switched-off view shows full and empty as usual, every other flag low
    task automatic chk(input int b, input logic eu, input logic em, input string m);
        logic eo;
        eo = (b < 2) ? eu : 1'b0;
        n_compared++;
        if (fl_u[b] !== eu || fl_m[b] !== em || fl_o[b] !== eo) begin
            n_mismatch++;
            $display("[ERR] %0t %s got %b/%b/%b", $time, m, fl_u[b], fl_m[b], fl_o[b]);
        end
    endtask

    task automatic chk_data(input logic [W-1:0] e);
        n_compared++;
        if (rd_u !== e || rd_m !== e || rd_o !== e) begin
            n_mismatch++;
            $display("[ERR] %0t read data %h/%h/%h want %h", $time, rd_u, rd_m, rd_o, e);
        end
    endtask

    // one clock of requests, then every output judged after the edge settles
    task automatic step(input logic w, input logic r, input logic [W-1:0] d);
        logic aw;
        logic ar;
        aw = w && level < D;
        ar = r && level > 0;
        user_u.drive(w, r, d);
        @(posedge clock);
        #1;
        if (aw) q.push_back(d);
        if (ar) exp_rd = q.pop_front();
        level = level + int'(aw) - int'(ar);
        if (level >= FULL_ASSERT_DEF) pf_m = 1'b1;
        else if (level < FULL_NEGATE_DEF) pf_m = 1'b0;
        if (level <= EMPTY_ASSERT_DEF) pe_m = 1'b1;
        else if (level > EMPTY_NEGATE_DEF) pe_m = 1'b0;
        chk(0, level == D, level == D, "full");
        chk(1, level == 0, level == 0, "empty");
        chk(2, level == D - 1, level == D - 1, "near full");
        chk(3, level == 1, level == 1, "near empty");
        chk(4, level >= FULL_ASSERT_DEF, pf_m, "prog full");
        chk(5, level <= EMPTY_ASSERT_DEF, pe_m, "prog empty");
        chk(6, aw, !aw, "write ack");
        chk(7, w && !aw, !(w && !aw), "overflow");
        chk(8, ar, !ar, "read valid");
        chk(9, r && !ar, !(r && !ar), "underflow");
        chk_data(exp_rd);
    endtask

    // values held in reset, then release
    task automatic test_reset();
        repeat (5) @(posedge clock);
        #1;
        chk(0, 1'b0, 1'b1, "full in reset");
        chk(2, 1'b0, 1'b1, "near full in reset");
        chk(4, 1'b0, 1'b1, "prog full in reset");
        chk(1, 1'b1, 1'b1, "empty in reset");
        chk(6, 1'b0, 1'b1, "ack idle in reset");
        chk(9, 1'b0, 1'b1, "underflow idle in reset");
        chk_data('0);
        rstn = 1'b1;
        step(1'b0, 1'b0, '0);
        $display("test reset done");
    endtask

    // back-to-back writes to full, refused write, write with read while full
    task automatic test_fill();
        for (int i = 0; i < D; i++) begin
            step(1'b1, 1'b0, W'(i * 3 + 5));
        end
        step(1'b1, 1'b0, W'(18'h2aaaa));
        step(1'b1, 1'b1, W'(18'h15555));
        step(1'b1, 1'b0, W'(18'h0f0f0));
        $display("test fill done");
    endtask

    // back-to-back reads to empty, refused read, read with write while empty
    task automatic test_drain();
        for (int i = 0; i < D; i++) begin
            step(1'b0, 1'b1, '0);
        end
        step(1'b0, 1'b1, '0);
        step(1'b1, 1'b1, W'(18'h3c3c3));
        step(1'b0, 1'b1, '0);
        $display("test drain done");
    endtask

    // main sequence
    initial begin
        exp_rd = '0;
        pf_m = 1'b0;
        pe_m = 1'b1;
        test_reset();
        test_fill();
        test_drain();
        end_sim();
    end

    // about 80 cycles expected; cut a hang well past that
    initial begin
        #20000;
        n_mismatch++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
